// ---- gpio_cfg_map.vh ----
// Register map, field positions and reset values of the pin configuration block
`ifndef GPIO_CFG_MAP_VH
`define GPIO_CFG_MAP_VH
// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_DCD_CFG 8'h40
`define IDX_RX_CFG 8'h41
`define IDX_TX_CFG 8'h42
`define IDX_DSR_CFG 8'h43
`define IDX_RTS_CFG 8'h44
`define IDX_CTS_CFG 8'h45
`define IDX_DTR_CFG 8'h46
`define IDX_IND_CFG 8'h47
`define IDX_DATA5 8'h4F
`define IDX_DATA6 8'h50
`define IDX_PIN_LVL 8'h60
`define IDX_RESET_SRC 8'h61
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_DIR 0
`define BIT_INV 1
`define FN_HI 3
`define FN_LO 2
`define BIT_OD 7
`define CFG_KEEP 8'h8F
// ----------------------------------------------------------------
// Function codes and reset values
// ----------------------------------------------------------------
`define FN_GPIO 2'b00
`define FN_ALT1 2'b01
`define FN_ALT2 2'b10
`define CFG_RST_IN 8'h01
`define CFG_RST_ZERO 8'h00
`define DATA_RST 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ZERO32 32'h0000_0000
`endif

// ---- pin_sync.v ----
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] async_in,
   output reg [7:0] sync_out
);
   reg [7:0] stage1;
   always @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= 8'h00;
         sync_out <= 8'h00;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule
`default_nettype wire

// ---- pin_cell.v ----
// One configurable pin: direction, inversion, driver type and function mux
`default_nettype none
`include "gpio_cfg_map.vh"
module pin_cell (
   input wire [7:0] cfg,
   input wire data_bit,
   input wire alt1_out,
   input wire alt1_is_out,
   input wire pin_level,
   output wire pin_out,
   output wire pin_oe_n,
   output wire logic_in
);
   wire [1:0] fn;
   wire is_in;
   wire drive_val;
   assign fn = cfg[`FN_HI:`FN_LO];
   // Alternate output functions force output, alternate input functions force input; others follow the direction bit
   assign is_in = (fn == `FN_ALT1) ? !alt1_is_out : cfg[`BIT_DIR];
   // Same inversion on the way in and the way out
   assign drive_val = ((fn == `FN_ALT1) ? alt1_out : data_bit) ^ cfg[`BIT_INV];
   assign logic_in = pin_level ^ cfg[`BIT_INV];
   assign pin_out = drive_val;
   // Open drain only pulls low; a high is left to the pull-up
   assign pin_oe_n = is_in | (cfg[`BIT_OD] & drive_val);
endmodule
`default_nettype wire

// ---- gpio_bank5_6_pin_config.v ----
// Configuration of bank 5 pins 1 to 7 and bank 6 pin 0 behind an AXI4-Lite slave
//
// The AXI4-Lite register port was left to the implementer.
`default_nettype none
`include "gpio_cfg_map.vh"
module gpio_bank5_6_pin_config (
   input wire aclk,
   input wire aresetn,
   input wire standby_power_on_reset,
   input wire main_power_reset,
   input wire hard_reset,
   input wire [9:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [9:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [7:0] pin_in,
   output reg [7:0] pin_out,
   output reg [7:0] pin_oe_n,
   input wire uart_b_transmit_line,
   input wire uart_b_request_send_n,
   input wire uart_b_terminal_ready_n,
   output reg uart_b_carrier_detect_n,
   output reg uart_b_receive_line,
   output reg uart_b_set_ready_n,
   output reg uart_b_clear_send_n,
   input wire indicator_lamp_one_output,
   output reg edge_irq_four_event
);
   // Pin vector index: 0..6 are bank5 pins 1..7, 7 is bank6 pin0
   reg [7:0] cfg [0:7];
   reg [7:0] data5;
   reg data6;
   reg [2:0] last_reset;
   reg [9:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   reg irq_prev;
   wire [7:0] pin_sync_q;
   wire [7:0] logic_in;
   wire [7:0] cell_out;
   wire [7:0] cell_oe_n;
   wire [7:0] alt_out;
   wire [7:0] alt_is_out;
   wire [7:0] data_vec;
   wire do_write;
   wire [7:0] wr_idx;
   wire [7:0] rd_idx;
   wire [7:0] wbyte;
   integer i;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function [7:0] word_index;
      input [9:0] addr;
      begin
         word_index = addr[9:2];
      end
   endfunction

   function is_cfg;
      input [7:0] idx;
      begin
         is_cfg = (idx >= `IDX_DCD_CFG) && (idx <= `IDX_IND_CFG);
      end
   endfunction

   function [2:0] cfg_slot;
      input [7:0] idx;
      reg [7:0] off;
      begin
         off = idx - `IDX_DCD_CFG;
         cfg_slot = off[2:0];
      end
   endfunction

   // Reserved codes fall back to plain GPIO so a stray write cannot grab a pin
   function [1:0] legal_fn;
      input [1:0] fn;
      input is_bank6;
      begin
         if (fn == `FN_GPIO || fn == `FN_ALT1) begin
            legal_fn = fn;
         end else if (fn == `FN_ALT2 && is_bank6) begin
            legal_fn = fn;
         end else begin
            legal_fn = `FN_GPIO;
         end
      end
   endfunction

   function [7:0] cfg_filter;
      input [7:0] v;
      input is_bank6;
      reg [7:0] t;
      begin
         t = v & `CFG_KEEP;
         t[`FN_HI:`FN_LO] = legal_fn(v[`FN_HI:`FN_LO], is_bank6);
         cfg_filter = t;
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   pin_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(pin_in),
      .sync_out(pin_sync_q)
   );

   assign data_vec = {data6, data5[7:1]};
   // Alternate outputs: transmit, request-to-send, terminal-ready, indicator
   assign alt_out = {indicator_lamp_one_output, uart_b_terminal_ready_n, 1'b0,
                     uart_b_request_send_n, 1'b0, uart_b_transmit_line, 2'b00};
   assign alt_is_out = 8'b1101_0100;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : cells
         pin_cell u_cell (
            .cfg(cfg[g]),
            .data_bit(data_vec[g]),
            .alt1_out(alt_out[g]),
            .alt1_is_out(alt_is_out[g]),
            .pin_level(pin_sync_q[g]),
            .pin_out(cell_out[g]),
            .pin_oe_n(cell_oe_n[g]),
            .logic_in(logic_in[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pin and serial-port outputs
   // ----------------------------------------------------------------
   // Edge interrupt input forces the bank6 pin to input
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 8'h00;
         pin_oe_n <= 8'hFF;
         uart_b_carrier_detect_n <= 1'b1;
         uart_b_receive_line <= 1'b1;
         uart_b_set_ready_n <= 1'b1;
         uart_b_clear_send_n <= 1'b1;
         edge_irq_four_event <= 1'b0;
         irq_prev <= 1'b0;
      end else begin
         pin_out <= cell_out;
         pin_oe_n <= cell_oe_n;
         if (cfg[7][`FN_HI:`FN_LO] == `FN_ALT2) begin
            pin_oe_n[7] <= 1'b1;
         end
         // Idle level when not routed keeps the serial port quiet
         uart_b_carrier_detect_n <= (cfg[0][`FN_HI:`FN_LO] == `FN_ALT1) ?
                                    logic_in[0] : 1'b1;
         uart_b_receive_line <= (cfg[1][`FN_HI:`FN_LO] == `FN_ALT1) ?
                                logic_in[1] : 1'b1;
         uart_b_set_ready_n <= (cfg[3][`FN_HI:`FN_LO] == `FN_ALT1) ?
                               logic_in[3] : 1'b1;
         uart_b_clear_send_n <= (cfg[5][`FN_HI:`FN_LO] == `FN_ALT1) ?
                                logic_in[5] : 1'b1;
         irq_prev <= logic_in[7];
         edge_irq_four_event <= (cfg[7][`FN_HI:`FN_LO] == `FN_ALT2) &&
                                (irq_prev != logic_in[7]);
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx = word_index(aw_addr);
   assign wbyte = w_data[7:0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 10'h000;
         w_data <= `ZERO32;
         w_strb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (is_cfg(wr_idx) || wr_idx == `IDX_DATA5 ||
                            wr_idx == `IDX_DATA6) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   // Sideband resets take effect on the clock; standby reset also clears data
   always @(posedge aclk) begin
      if (!aresetn || standby_power_on_reset) begin
         for (i = 0; i < 8; i = i + 1) begin
            cfg[i] <= `CFG_RST_IN;
         end
         cfg[2] <= `CFG_RST_ZERO;
         data5 <= `DATA_RST;
         data6 <= 1'b0;
         last_reset <= 3'b001;
      end else begin
         if (main_power_reset || hard_reset) begin
            cfg[2] <= `CFG_RST_ZERO;
            data5[3] <= 1'b0;
            last_reset <= {hard_reset, main_power_reset, 1'b0};
         end else if (do_write && w_strb[0]) begin
            if (is_cfg(wr_idx)) begin
               cfg[cfg_slot(wr_idx)] <= cfg_filter(wbyte, wr_idx == `IDX_IND_CFG);
            end
            if (wr_idx == `IDX_DATA5) begin
               data5 <= wbyte;
            end
            if (wr_idx == `IDX_DATA6) begin
               data6 <= wbyte[0];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------
   assign rd_idx = word_index(s_axi_araddr);

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= `ZERO32;
         s_axi_rresp <= `RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= `ZERO32;
            if (is_cfg(rd_idx)) begin
               s_axi_rdata[7:0] <= cfg[cfg_slot(rd_idx)];
            end else if (rd_idx == `IDX_DATA5) begin
               s_axi_rdata[7:0] <= data5;
            end else if (rd_idx == `IDX_DATA6) begin
               s_axi_rdata[0] <= data6;
            end else if (rd_idx == `IDX_PIN_LVL) begin
               // Logical input levels after inversion
               s_axi_rdata[7:0] <= logic_in;
            end else if (rd_idx == `IDX_RESET_SRC) begin
               s_axi_rdata[2:0] <= last_reset;
            end else begin
               s_axi_rresp <= `RESP_SLVERR;
            end
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ---- gpio_cfg_properties.sv ----
// Assertions on the ports of the pin configuration block
`default_nettype none
module gpio_cfg_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] pin_oe_n,
   input wire logic uart_b_carrier_detect_n,
   input wire logic edge_irq_four_event
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_write_answered: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
   a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write answer dropped");
   a_read_answered: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer changed");
   a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   a_resp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'b00, 2'b10})
      else $error("bad write response");
   a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("ready while busy");
   a_reset_idle: assert property ($rose(aresetn) |-> pin_oe_n == 8'hFF
      && uart_b_carrier_detect_n) else $error("pins not idle after reset");
   a_irq_input: assert property (edge_irq_four_event |-> pin_oe_n[7])
      else $error("edge event on driven pin");
endmodule
bind gpio_bank5_6_pin_config gpio_cfg_properties i_props (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pin_oe_n,
   .uart_b_carrier_detect_n, .edge_irq_four_event);
`default_nettype wire

// ---- board_pins.sv ----
// Board side of the eight pins: pull-ups and an external driver per pin
`default_nettype none
module board_pins (
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe_n,
   input wire logic [7:0] ext_level,
   input wire logic [7:0] ext_drive,
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins with no external driver float up, so an open-drain one reads high
   always_comb
      for (int i = 0; i < 8; i++)
         pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_drive[i] ? ext_level[i] : 1'b1);
endmodule
`default_nettype wire

// ---- gpio_bank5_6_pin_config_test.sv ----
// Self-checking bench for the pin configuration block
`default_nettype none
module gpio_bank5_6_pin_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, standby_power_on_reset = 1, main_power_reset = 0;
   logic hard_reset = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, indicator_lamp_one_output = 0;
   logic uart_b_transmit_line = 1, uart_b_request_send_n = 1, uart_b_terminal_ready_n = 1;
   logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, d;
   logic [3:0] s_axi_wstrb = 0;
   logic [7:0] ext_level = 0, ext_drive = 0;
   logic [1:0] r;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [7:0] pin_in, pin_out, pin_oe_n;
   wire logic uart_b_carrier_detect_n, uart_b_receive_line, uart_b_set_ready_n;
   wire logic uart_b_clear_send_n, edge_irq_four_event;
   int cfg_m[8] = '{1, 1, 0, 1, 1, 1, 1, 1};
   int v, e, pulses, mismatches, n_checks;
   gpio_bank5_6_pin_config i_dut (.aclk, .aresetn, .standby_power_on_reset, .main_power_reset,
      .hard_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .pin_in, .pin_out, .pin_oe_n, .uart_b_transmit_line, .uart_b_request_send_n,
      .uart_b_terminal_ready_n, .uart_b_carrier_detect_n, .uart_b_receive_line,
      .uart_b_set_ready_n, .uart_b_clear_send_n, .indicator_lamp_one_output,
      .edge_irq_four_event);
   board_pins i_board (.pin_out, .pin_oe_n, .ext_level, .ext_drive, .pin_in);
   always #20 aclk = ~aclk;
   // Counted off the sampling edge to stay clear of update races
   always @(negedge aclk) if (edge_irq_four_event === 1'b1) pulses++;
   // ------------------------------------------------
   // Bus cycles and comparison
   // ------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] s);
      n_checks++;
      if (s !== ex) begin
         mismatches++;
         $display("BAD %s exp %h got %h", nm, ex, s);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] dv, input logic [3:0] st,
                     output logic [1:0] rs);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, dv};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      // Late ready makes the answer wait, so its hold is exercised
      repeat (2) @(posedge aclk);
      s_axi_bready <= 1;
      do @(posedge aclk); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] idx, output logic [31:0] dv, output logic [1:0] rs);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      @(posedge aclk);
      s_axi_rready <= 1;
      do @(posedge aclk); while (!s_axi_rvalid);
      dv = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   // Reserved function codes are kept as plain GPIO and bits 6:4 never stick
   function automatic int keep(int i, int x);
      int fn = (x >> 2) & 3;
      if (fn == 3 || (fn == 2 && i < 7)) x = x & 8'h83;
      return x & 8'h8F;
   endfunction
   task automatic wcfg(input int i, input int x);
      wr(8'h40 + i[7:0], x[7:0], 4'h1, r);
      cfg_m[i] = keep(i, x);
   endtask
   task automatic check_cfgs;
      for (int i = 0; i < 8; i++) begin
         rd(8'h40 + i[7:0], d, r);
         chk("cfg", cfg_m[i], d);
      end
   endtask
   task automatic give_verdict;
      if (mismatches == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   initial begin
      void'($urandom(40882));
      repeat (4) @(posedge aclk);
      aresetn <= 1;
      standby_power_on_reset <= 0;
      check_cfgs();
      rd(8'h4F, d, r);
      chk("data5", 0, d);
      rd(8'h48, d, r);
      chk("unmapped rd", 2, r);
      wr(8'h48, 8'hFF, 4'h1, r);
      chk("unmapped wr", 2, r);
      wr(8'h40, 8'h80, 4'h0, r);
      check_cfgs();
      for (int k = 0; k < 32; k++) begin
         v = ($urandom & 8'hF3) | (((k / 8) % 4) << 2);
         wcfg(k % 8, v);
         rd(8'h40 + k[2:0], d, r);
         chk("cfg back", cfg_m[k % 8], d);
      end
      for (int m = 0; m < 4; m++) begin
         for (int i = 0; i < 8; i++) wcfg(i, (m & 2) << 6 | (m & 1) << 1);
         v = $urandom & 8'hFF;
         wr(8'h4F, v[7:0], 4'h1, r);
         wr(8'h50, {7'h00, v[0]}, 4'h1, r);
         repeat (4) @(posedge aclk);
         chk("serial idle", 4'hF, {uart_b_carrier_detect_n, uart_b_receive_line,
            uart_b_set_ready_n, uart_b_clear_send_n});
         for (int i = 0; i < 8; i++) begin
            e = ((i < 7 ? v >> (i + 1) : v) & 1) ^ (m & 1);
            chk("pin level", e, pin_in[i]);
            chk("pin oe_n", (m & 2) ? e : 0, pin_oe_n[i]);
         end
         rd(8'h50, d, r);
         chk("data6", v & 1, d);
      end
      ext_drive <= 8'hFF;
      for (int m = 0; m < 2; m++) begin
         for (int i = 0; i < 8; i++) wcfg(i, 1 | m << 1);
         v = $urandom & 8'hFF;
         ext_level <= v[7:0];
         repeat (5) @(posedge aclk);
         rd(8'h60, d, r);
         chk("logic level", (m ? ~v : v) & 8'hFF, d);
      end
      for (int i = 0; i < 8; i++) wcfg(i, (i == 2 || i == 4 || i >= 6) ? 4 : 5);
      ext_drive <= 8'h2B;
      for (int k = 0; k < 3; k++) begin
         v = $urandom;
         ext_level <= v[7:0];
         {uart_b_transmit_line, uart_b_request_send_n} <= v[11:10];
         {uart_b_terminal_ready_n, indicator_lamp_one_output} <= v[9:8];
         repeat (5) @(posedge aclk);
         chk("serial in", {v[0], v[1], v[3], v[5]}, {uart_b_carrier_detect_n,
            uart_b_receive_line, uart_b_set_ready_n, uart_b_clear_send_n});
         chk("alt out", v[11:8], {pin_in[2], pin_in[4], pin_in[6], pin_in[7]});
      end
      ext_drive <= 8'h80;
      for (int j = 0; j < 2; j++) begin
         wcfg(7, j ? 8'h01 : 8'h09);
         repeat (5) @(posedge aclk);
         pulses = 0;
         for (int k = 0; k < 4; k++) begin
            ext_level <= ext_level ^ 8'h80;
            repeat (8) @(posedge aclk);
         end
         chk("edge events", j ? 0 : 4, pulses);
      end
      for (int j = 0; j < 2; j++) begin
         wcfg(2, 8'h84);
         wr(8'h4F, 8'hFF, 4'h1, r);
         main_power_reset <= !j;
         hard_reset <= j[0];
         @(posedge aclk);
         main_power_reset <= 0;
         hard_reset <= 0;
         cfg_m[2] = 0;
         check_cfgs();
         rd(8'h4F, d, r);
         chk("data5 bit3", 8'hF6, d & 8'hFE);
         rd(8'h61, d, r);
         chk("reset src", j ? 4 : 2, d);
      end
      standby_power_on_reset <= 1;
      @(posedge aclk);
      standby_power_on_reset <= 0;
      cfg_m = '{1, 1, 0, 1, 1, 1, 1, 1};
      check_cfgs();
      rd(8'h4F, d, r);
      chk("data5 standby", 0, d);
      rd(8'h61, d, r);
      chk("reset src", 1, d);
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
